/* File: design/sac_conv_ctrl.sv */
/*
 * Conversion sequencing and serial result output of a 16-bit successive
 * approximation converter, with an APB register file and one interrupt.
 * Assumes a 50 MHz clock; all pins except APB, clock and reset are asynchronous and are
 * synchronised here; the comparator answers the trial code within one
 * conversion clock.
 */
`timescale 1ns/1ps
`include "sac_regs.svh"
module sac_conv_ctrl (
  input  wire logic        SYS_CLK_IN,                    // System clock
  input  wire logic        RST_IN,                        // Sync reset, high
  input  wire logic        PSEL_IN,                       // APB select
  input  wire logic        PENABLE_IN,                    // APB enable
  input  wire logic        PWRITE_IN,                     // APB direction
  input  wire logic [7:0]  PADDR_IN,                      // APB address
  input  wire logic [31:0] PWDATA_IN,                     // APB write data
  output logic      [31:0] PRDATA_OUT,                    // APB read data
  output logic             PREADY_OUT,                    // APB ready
  output logic             PSLVERR_OUT,                   // APB error
  input  wire logic        CONVERT_STROBE_IN,             // Convert strobe
  input  wire logic        PREVIOUS_RESULT_CAPTURE_IN,    // Capture request
  input  wire logic        PREVIOUS_RESULT_READ_CLOCK_IN, // Read clock
  input  wire logic        EXT_CLK_IN,                    // External conv clock
  input  wire logic        COMPARATOR_IN,                 // High: input >= trial
  output logic      [15:0] TRIAL_CODE_OUT,                // Trial code to DAC
  output logic             BUSY_OUT,                      // Conversion running
  output logic             CLK_OUT,                       // Active conv clock
  output logic             REALTIME_SERIAL_OUT,           // Realtime bit
  output logic             PREVIOUS_RESULT_SERIAL_OUT,    // Previous result
  output logic             MSB_N_OUT,                     // Inverted MSB
  output logic             IRQ_OUT                        // Interrupt level
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic conv_q2;
  logic capt_q2;
  logic rdclk_q2;
  logic ext_q2;
  logic cmp_q2;
  logic conv_q3_ff;
  logic rdclk_q3_ff;
  logic ext_q3_ff;

  sac_sync2 u_sync_conv  (.clk_in(SYS_CLK_IN), .rst_in(RST_IN), .async_in(CONVERT_STROBE_IN),
                          .sync_out(conv_q2));
  sac_sync2 u_sync_capt  (.clk_in(SYS_CLK_IN), .rst_in(RST_IN), .async_in(PREVIOUS_RESULT_CAPTURE_IN),
                          .sync_out(capt_q2));
  sac_sync2 u_sync_rdclk (.clk_in(SYS_CLK_IN), .rst_in(RST_IN), .async_in(PREVIOUS_RESULT_READ_CLOCK_IN),
                          .sync_out(rdclk_q2));
  sac_sync2 u_sync_ext   (.clk_in(SYS_CLK_IN), .rst_in(RST_IN), .async_in(EXT_CLK_IN),
                          .sync_out(ext_q2));
  sac_sync2 u_sync_cmp   (.clk_in(SYS_CLK_IN), .rst_in(RST_IN), .async_in(COMPARATOR_IN),
                          .sync_out(cmp_q2));

  // Delayed copies for edge detection; reset to the synchroniser level so no false fall follows reset
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      conv_q3_ff  <= 1'b0;
      rdclk_q3_ff <= 1'b0;
      ext_q3_ff   <= 1'b0;
    end else begin
      conv_q3_ff  <= conv_q2;
      rdclk_q3_ff <= rdclk_q2;
      ext_q3_ff   <= ext_q2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and decode

  logic [7:0]  ctrl_ff;
  logic [2:0]  irq_sts_ff;
  logic [2:0]  irq_mask_ff;
  logic [15:0] result_ff;
  logic [15:0] prev_ff;
  logic [15:0] prev_shift_ff;
  sac_pkg::sac_state_t state_ff;
  sac_pkg::sac_state_t nxt_state;
  logic [4:0]  cyc_ff;

  wire         coding_twos = ctrl_ff[`SAC_CTRL_CODING_BIT];
  wire         clk_ext     = ctrl_ff[`SAC_CTRL_CLKSEL_BIT];
  wire  [3:0]  short_len   = ctrl_ff[`SAC_CTRL_SHORT_MSB:`SAC_CTRL_SHORT_LSB];
  wire  [4:0]  n_bits      = (short_len == 4'h0) ? `SAC_FULL_BITS : {1'b0, short_len};
  wire         apb_access  = PSEL_IN && PENABLE_IN;
  wire         apb_done    = apb_access && PREADY_OUT;
  wire         apb_wr      = apb_done && PWRITE_IN;
  wire         sel_ctrl    = (PADDR_IN == `SAC_CTRL_OFS);
  wire         sel_status  = (PADDR_IN == `SAC_STATUS_OFS);
  wire         sel_result  = (PADDR_IN == `SAC_RESULT_OFS);
  wire         sel_prev    = (PADDR_IN == `SAC_PREV_OFS);
  wire         sel_ists    = (PADDR_IN == `SAC_IRQ_STS_OFS);
  wire         sel_imask   = (PADDR_IN == `SAC_IRQ_MASK_OFS);
  wire         addr_ok     = sel_ctrl | sel_status | sel_result | sel_prev | sel_ists | sel_imask;
  wire  [31:0] rd_mux      = sel_ctrl   ? {24'h000000, ctrl_ff} :
                             sel_status ? {17'h00000, cyc_ff, 6'h00, state_ff, BUSY_OUT, IRQ_OUT} :
                             sel_result ? {16'h0000, result_ff} :
                             sel_prev   ? {16'h0000, prev_ff} :
                             sel_ists   ? {29'h00000000, irq_sts_ff} :
                             sel_imask  ? {29'h00000000, irq_mask_ff} : 32'h00000000;

  // One wait state: data and ready registered in the first access cycle
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      PREADY_OUT  <= 1'b0;
      PRDATA_OUT  <= 32'h00000000;
      PSLVERR_OUT <= 1'b0;
    end else begin
      PREADY_OUT  <= apb_access && !PREADY_OUT;
      PRDATA_OUT  <= (apb_access && !PWRITE_IN) ? rd_mux : 32'h00000000;
      PSLVERR_OUT <= apb_access && !PREADY_OUT && !addr_ok;
    end
  end

  // Writable registers
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      ctrl_ff     <= `SAC_CTRL_RESET;
      irq_mask_ff <= 3'h0;
    end else begin
      if (apb_wr && sel_ctrl) begin
        ctrl_ff <= PWDATA_IN[7:0];
      end
      if (apb_wr && sel_imask) begin
        irq_mask_ff <= PWDATA_IN[2:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion clock: internal divider or synchronised external clock

  logic [3:0] div_ff;
  logic       int_clk_ff;
  wire        div_wrap = (div_ff == 4'(`SAC_INT_HALF - 1));
  wire        int_tick = div_wrap && !int_clk_ff;
  wire        ext_tick = ext_q2 && !ext_q3_ff;
  wire        tick     = clk_ext ? ext_tick : int_tick;

  // Internal oscillator, free running, equal high and low halves
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      div_ff     <= 4'h0;
      int_clk_ff <= 1'b0;
      CLK_OUT    <= 1'b0;
    end else begin
      div_ff     <= div_wrap ? 4'h0 : div_ff + 4'h1;
      int_clk_ff <= div_wrap ? !int_clk_ff : int_clk_ff;
      CLK_OUT    <= clk_ext ? ext_q2 : int_clk_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  wire        conv_fall  = conv_q3_ff && !conv_q2;
  wire        rd_rise    = rdclk_q2 && !rdclk_q3_ff;
  wire        capt_evt   = rd_rise && capt_q2;
  wire        int_start  = capt_evt && !conv_q2 && (state_ff != sac_pkg::SAC_CONV);
  wire        start      = (conv_fall || int_start) && (state_ff != sac_pkg::SAC_CONV);
  wire        in_conv    = (state_ff == sac_pkg::SAC_CONV);
  wire        finish     = in_conv && tick && (cyc_ff == n_bits);
  wire        abort      = in_conv && conv_q2;
  wire [3:0]  bit_idx    = 4'(5'h10 - cyc_ff);
  wire        bit_val    = cmp_q2;
  wire [15:0] trial_keep = bit_val ? TRIAL_CODE_OUT : (TRIAL_CODE_OUT & ~(16'h0001 << bit_idx));
  wire [15:0] trial_next = (cyc_ff < n_bits) ? (trial_keep | (16'h0001 << (bit_idx - 4'h1))) : trial_keep;
  wire [15:0] code_final = coding_twos ? {~trial_keep[15], trial_keep[14:0]} : trial_keep;
  wire        rt_bit     = (coding_twos && bit_idx == 4'hf) ? !bit_val : bit_val;

  // Next state
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      sac_pkg::SAC_HALT: nxt_state = start ? sac_pkg::SAC_CONV : sac_pkg::SAC_HALT;
      sac_pkg::SAC_CONV: nxt_state = conv_q2 ? sac_pkg::SAC_HALT :
                                     (finish ? sac_pkg::SAC_DONE : sac_pkg::SAC_CONV);
      sac_pkg::SAC_DONE: nxt_state = conv_q2 ? sac_pkg::SAC_HALT :
                                     (start ? sac_pkg::SAC_CONV : sac_pkg::SAC_DONE);
      default:           nxt_state = sac_pkg::SAC_HALT;
    endcase
  end

  // State, cycle count, trial code and busy flag
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      state_ff       <= sac_pkg::SAC_HALT;
      cyc_ff         <= 5'h00;
      TRIAL_CODE_OUT <= 16'h0000;
      BUSY_OUT       <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      BUSY_OUT <= (nxt_state == sac_pkg::SAC_CONV);
      if (nxt_state == sac_pkg::SAC_HALT) begin
        cyc_ff         <= 5'h00;
        TRIAL_CODE_OUT <= 16'h0000;
      end else if (start) begin
        cyc_ff         <= 5'h00;
        TRIAL_CODE_OUT <= 16'h0000;
      end else if (in_conv && tick) begin
        cyc_ff         <= cyc_ff + 5'h01;
        TRIAL_CODE_OUT <= (cyc_ff == 5'h00) ? 16'h8000 : trial_next;
      end
    end
  end

  // Realtime bit, result and inverted MSB
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      REALTIME_SERIAL_OUT <= 1'b0;
      result_ff           <= 16'h0000;
      MSB_N_OUT           <= 1'b1;
    end else begin
      if (in_conv && tick && cyc_ff != 5'h00) begin
        REALTIME_SERIAL_OUT <= rt_bit;
      end
      if (finish) begin
        result_ff <= code_final;
        MSB_N_OUT <= !code_final[15];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Previous result register and secondary shift port

  // Capture loads the latest result; read clock shifts MSB first
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      prev_ff                    <= 16'h0000;
      prev_shift_ff              <= 16'h0000;
      PREVIOUS_RESULT_SERIAL_OUT <= 1'b0;
    end else begin
      if (finish) begin
        prev_ff <= result_ff;
      end
      if (capt_evt) begin
        prev_shift_ff              <= result_ff;
        PREVIOUS_RESULT_SERIAL_OUT <= result_ff[15];
      end else if (rd_rise) begin
        prev_shift_ff              <= {prev_shift_ff[14:0], 1'b0};
        PREVIOUS_RESULT_SERIAL_OUT <= prev_shift_ff[14];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: sticky status, set wins over write-one clear

  wire [2:0] irq_set = {abort, capt_evt, finish};
  wire [2:0] irq_clr = (apb_wr && sel_ists) ? PWDATA_IN[2:0] : 3'h0;
  wire [2:0] nxt_sts = irq_set | (irq_sts_ff & ~irq_clr);

  // Status bits and interrupt level
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      irq_sts_ff <= 3'h0;
      IRQ_OUT    <= 1'b0;
    end else begin
      irq_sts_ff <= nxt_sts;
      IRQ_OUT    <= |(nxt_sts & irq_mask_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [4:0] tick_cnt_ff;

  // Conversion clocks counted independently of the sequencer
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN || start) begin
      tick_cnt_ff <= 5'h00;
    end else if (in_conv && tick) begin
      tick_cnt_ff <= tick_cnt_ff + 5'h01;
    end
  end

  property p_start_fall;
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
      (conv_fall && !in_conv) |=> BUSY_OUT && cyc_ff == 5'h00;
  endproperty
  a_start_fall: assert property (p_start_fall) else $error("No start on strobe fall");

  property p_halt;
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
      conv_q2 ##1 conv_q2 |=> state_ff == sac_pkg::SAC_HALT && !BUSY_OUT;
  endproperty
  a_halt: assert property (p_halt) else $error("Not halted while strobe high");

  property p_busy;
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
      $fell(BUSY_OUT) |-> $past(finish) || $past(conv_q2);
  endproperty
  a_busy: assert property (p_busy) else $error("Busy dropped early");

  property p_seventeen;
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
      (finish && short_len == 4'h0) |=> tick_cnt_ff == 5'd17;
  endproperty
  a_seventeen: assert property (p_seventeen) else $error("Conversion not 17 clocks");

  property p_short;
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
      (finish && short_len != 4'h0) |=> tick_cnt_ff == {1'b0, $past(short_len)} + 5'h01;
  endproperty
  a_short: assert property (p_short) else $error("Short cycle length wrong");

  property p_capture;
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
      capt_evt |=> prev_shift_ff == $past(result_ff) && PREVIOUS_RESULT_SERIAL_OUT == prev_shift_ff[15];
  endproperty
  a_capture: assert property (p_capture) else $error("Capture did not load");

  property p_shift;
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
      (rd_rise && !capt_q2) |=> prev_shift_ff == {$past(prev_shift_ff[14:0]), 1'b0};
  endproperty
  a_shift: assert property (p_shift) else $error("Read clock did not shift");

  property p_clk_out;
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
      1'b1 |=> CLK_OUT == ($past(clk_ext) ? $past(ext_q2) : $past(int_clk_ff));
  endproperty
  a_clk_out: assert property (p_clk_out) else $error("Clock output not active clock");

  property p_msb_n;
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
      finish |=> MSB_N_OUT != result_ff[15] && result_ff[14:0] == $past(trial_keep[14:0]);
  endproperty
  a_msb_n: assert property (p_msb_n) else $error("MSB output not inverted");

  property p_coding;
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
      finish |=> result_ff[15] == ($past(coding_twos) ^ $past(trial_keep[15]));
  endproperty
  a_coding: assert property (p_coding) else $error("Output coding wrong");

endmodule // sac_conv_ctrl

/* File: design/sac_regs.svh */
/*
 * Register offsets, field positions, reset values and timing counts of the
 * serial conversion control block.
 * Assumes a 50 MHz system clock and APB byte addresses.
 */
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH

// Register byte offsets
`define SAC_CTRL_OFS        8'h00
`define SAC_STATUS_OFS      8'h04
`define SAC_RESULT_OFS      8'h08
`define SAC_PREV_OFS        8'h0c
`define SAC_IRQ_STS_OFS     8'h10
`define SAC_IRQ_MASK_OFS    8'h14

// Control fields
`define SAC_CTRL_CODING_BIT 0
`define SAC_CTRL_CLKSEL_BIT 1
`define SAC_CTRL_SHORT_LSB  4
`define SAC_CTRL_SHORT_MSB  7
`define SAC_CTRL_RESET      8'h03

// Interrupt bits
`define SAC_IRQ_DONE_BIT    0
`define SAC_IRQ_CAPT_BIT    1
`define SAC_IRQ_ABORT_BIT   2

// Timing
`define SAC_SYS_PERIOD_NS   20
`define SAC_CONV_MAX_NS     5000
`define SAC_CONV_TYP_NS     4000
`define SAC_CONV_CLOCKS     17
`define SAC_FULL_BITS       5'h10
`define SAC_INT_HALF        ((`SAC_CONV_MAX_NS / (`SAC_CONV_CLOCKS * `SAC_SYS_PERIOD_NS)) / 2)

`endif

/* File: design/sac_pkg.sv */
/*
 * Types shared by the serial conversion control block.
 * Assumes nothing of its surroundings.
 */
package sac_pkg;
  // Converter sequencing states
  typedef enum logic [1:0] {
    SAC_HALT = 2'b00,
    SAC_CONV = 2'b01,
    SAC_DONE = 2'b10
  } sac_state_t;
endpackage

/* File: design/sac_sync2.sv */
/*
 * Two flip-flop synchroniser for one asynchronous input.
 * Assumes the input may change at any time relative to the clock.
 */
`timescale 1ns/1ps
module sac_sync2 (
  input  wire logic clk_in,   // System clock
  input  wire logic rst_in,   // Synchronous reset, active high
  input  wire logic async_in, // Asynchronous level
  output logic      sync_out  // Synchronised level
);
  logic meta_ff;

  // First stage feeds only the second stage
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_ff  <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule // sac_sync2

/* File: test/sac_host_model.sv */
/*
 * Host model: latches the previous result and reads it from the secondary
 * serial port with its own slow read clock.
 * Assumes the block samples capture at read-clock rising edges.
 */
`timescale 1ns/1ps
module sac_host_model (
  input  wire logic        clk_in,         // System clock
  input  wire logic        rst_in,         // Sync reset, high
  input  wire logic        req_in,         // Start one readout
  input  wire logic        data_in,        // Secondary serial bit
  output logic             capture_out,    // Capture request
  output logic             read_clock_out, // Read clock, idle low
  output logic             done_out,       // Readout finished pulse
  output logic      [15:0] word_out        // Word read, MSB first
);
  logic       act_ff;
  logic [6:0] cnt_ff;

  ////////////////////////////////////////////////////////////////////////
  // Sixteen read clocks of 8 cycles; each bit is taken late in the low
  // phase so the block's synchroniser delay has run out
  always_ff @(posedge clk_in) begin
    done_out <= 1'b0;
    if (rst_in) begin
      act_ff         <= 1'b0;
      cnt_ff         <= 7'h00;
      capture_out    <= 1'b0;
      read_clock_out <= 1'b0;
      word_out       <= 16'h0000;
    end else if (req_in && !act_ff) begin
      act_ff      <= 1'b1;
      cnt_ff      <= 7'h00;
      capture_out <= 1'b1;
    end else if (act_ff) begin
      cnt_ff         <= cnt_ff + 7'h01;
      read_clock_out <= !cnt_ff[2];
      if (cnt_ff == 7'h06) begin
        capture_out <= 1'b0;
      end
      if (cnt_ff[2:0] == 3'h7) begin
        word_out <= {word_out[14:0], data_in};
      end
      if (cnt_ff == 7'h7f) begin
        act_ff   <= 1'b0;
        done_out <= 1'b1;
      end
    end
  end
endmodule // sac_host_model

/* File: test/tb_top.sv */
/*
 * Self-checking bench of the conversion control block.
 * Assumes a comparator model that keeps each trial bit at or below ain.
 */
`timescale 1ns/1ps
module tb_top;
  logic        clk, rst, psel, pen, pwr, stb, ext, req, clko_q;
  logic        pready, pslv, cap, rclk, busy, clko, rt, prs, msbn, irq, hdone;
  logic [7:0]  paddr;
  logic [31:0] pwd, prd;
  logic [15:0] trial, ain, hword, rt_sh, v, e;
  logic [15:0] tbl [4] = '{16'hffff, 16'h0000, 16'h8000, 16'h7fff};
  logic [32:0] exp_q [$];
  int          fails = 0, cmp_count = 0, nf = 0, n, bcnt;

  sac_conv_ctrl sac_conv_ctrl_inst (
    .SYS_CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwd), .PRDATA_OUT(prd), .PREADY_OUT(pready), .PSLVERR_OUT(pslv),
    .CONVERT_STROBE_IN(stb), .PREVIOUS_RESULT_CAPTURE_IN(cap), .PREVIOUS_RESULT_READ_CLOCK_IN(rclk),
    .EXT_CLK_IN(ext), .COMPARATOR_IN(ain >= trial), .TRIAL_CODE_OUT(trial), .BUSY_OUT(busy),
    .CLK_OUT(clko), .REALTIME_SERIAL_OUT(rt), .PREVIOUS_RESULT_SERIAL_OUT(prs), .MSB_N_OUT(msbn),
    .IRQ_OUT(irq));
  sac_host_model sac_host_model_inst (.clk_in(clk), .rst_in(rst), .req_in(req), .data_in(prs),
    .capture_out(cap), .read_clock_out(rclk), .done_out(hdone), .word_out(hword));

  ////////////////////////////////////////////////////////////////////////
  // System clock, and a free-running external clock of unrelated phase
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  initial begin
    ext = 0;
    #7;
    forever #80 ext = ~ext;
  end

  // Collects the realtime bit at every fall of the clock output
  always @(posedge clk) begin
    clko_q <= clko;
    if (clko_q && !clko) begin
      rt_sh <= {rt_sh[14:0], rt};
      nf    <= nf + 1;
    end
  end

  // Takes the oldest noted bus answer off the queue at each ready
  always @(posedge clk) if (pready === 1'b1 && psel && pen) check("apb answer", {pslv, prd}, exp_q.pop_front());

  task check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task end_sim;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // One APB transfer; the expected {error, data} is noted first
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] x);
    exp_q.push_back(x);
    @(posedge clk);
    {psel, pen, pwr, paddr, pwd} <= {2'b10, w, a, d};
    @(posedge clk);
    pen <= 1;
    n = 0;
    do @(negedge clk); while (pready !== 1'b1 && ++n < 20);
    if (n >= 20) fails++;
    @(posedge clk);
    {psel, pen} <= 2'b00;
  endtask

  // Raise strobe, check idle, drop it and wait for busy
  task start;
    @(posedge clk) stb <= 1;
    repeat (5) @(posedge clk);
    check("idle busy", busy, 0);
    stb <= 0;
    n = 0;
    do @(negedge clk); while (busy !== 1'b1 && ++n < 40);
    check("busy rise", busy, 1);
  endtask

  task conv(input logic [15:0] val);
    @(posedge clk) ain <= val;
    start;
    bcnt = 1;
    do begin @(negedge clk); bcnt++; end while (busy === 1'b1 && bcnt < 400);
  endtask

  initial begin
    {rst, psel, pen, pwr, paddr, pwd, stb, req, ain} = {1'b1, 43'h0, 1'b1, 17'h0};
    #1_000_000;
    fails++;
    $display("watchdog expired");
    end_sim;
  end

  initial begin
    void'($urandom(32'h1e502200));
    repeat (3) @(posedge clk);
    rst <= 0;
    apb(0, 8'h00, 0, 33'h3);
    apb(1, 8'h18, 32'hffffffff, {1'b1, 32'h0});
    apb(0, 8'h18, 0, {1'b1, 32'h0});
    apb(1, 8'h14, 32'h7, 33'h0);
    $display("test registers done");
    for (int c = 1; c >= 0; c--) begin
      apb(1, 8'h00, 32'h2 | c, 33'h0);
      for (int i = 0; i < 5; i++) begin
        v = (i < 4) ? tbl[i] : 16'($urandom);
        e = c ? v ^ 16'h8000 : v;
        conv(v);
        check("busy span", bcnt >= 128 && bcnt <= 144, 1);
        check("msb_n", msbn, !e[15]);
        n = nf;
        while (nf == n && bcnt++ < 440) @(negedge clk);
        check("realtime word", rt_sh, e);
        check("irq on", irq, 1);
        apb(0, 8'h08, 0, {17'h0, e});
        apb(1, 8'h10, 32'h1, 33'h0);
        repeat (2) @(negedge clk);
        check("irq cleared", irq, 0);
      end
    end
    $display("test coding done");
    apb(1, 8'h00, 32'h83, 33'h0);
    conv(16'hffff);
    check("short span", bcnt >= 64 && bcnt <= 80, 1);
    apb(0, 8'h08, 0, {17'h0, 16'h7f00});
    apb(1, 8'h00, 32'h01, 33'h0);
    v = 16'($urandom);
    conv(v);
    check("internal span", bcnt >= 224 && bcnt <= 250, 1);
    apb(0, 8'h0c, 0, {17'h0, 16'h7f00});
    @(posedge clk) req <= 1;
    @(posedge clk) req <= 0;
    n = 0;
    do @(negedge clk); while (hdone !== 1'b1 && ++n < 300);
    check("previous word", hword, v ^ 16'h8000);
    check("capture start", busy, 1);
    n = 0;
    do @(negedge clk); while (busy === 1'b1 && ++n < 300);
    $display("test capture done");
    apb(1, 8'h10, 32'h7, 33'h0);
    start;
    repeat (20) @(posedge clk);
    stb <= 1;
    repeat (5) @(negedge clk);
    check("abort busy", busy, 0);
    apb(0, 8'h10, 0, 33'h4);
    apb(0, 8'h04, 0, 33'h1);
    apb(1, 8'h14, 32'h0, 33'h0);
    repeat (2) @(negedge clk);
    check("irq masked", irq, 0);
    $display("test abort done");
    end_sim;
  end
endmodule // tb_top
